//--- hdl/cidl_lookup_top.sv
// AHB-Lite slave holding the two per-channel filter lookup helper registers.
// Assumes a single AHB-Lite master, word transfers only, one clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "cidl_map.svh"

// How it works
// - A write to an assist offset stores the received standard identifier in the addressed channel.
// - A read of an assist offset returns the converted identifier; the raw offsets return the held value.
// - Read value carries identifier bits 10 to 3 unchanged as a row index.
// - Identifier bits 2 to 0 are decoded one-hot: value n sets bit n.
// - Two independent registers, one for each controller channel.
module cidl_lookup_top
  import cidl_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite address phase
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // AHB-Lite data phase
  input wire logic [`CIDL_DATA_W-1:0] hwdata,
  output logic [`CIDL_DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // Slave phase state
  cidl_state_t state;
  cidl_state_t next_state;
  logic [`CIDL_ADDR_MSB:`CIDL_ADDR_LSB] addr_q;
  logic [`CIDL_ADDR_MSB:`CIDL_ADDR_LSB] next_addr_q;
  logic [`CIDL_DATA_W-1:0] next_hrdata;

  // Address phase qualifier
  logic take_req;

  // Per-channel write strobes and held values
  logic wr_ch0;
  logic wr_ch1;
  logic [`CIDL_ID_W-1:0] held_ch0;
  logic [`CIDL_ID_W-1:0] held_ch1;

  // Converted fields
  logic [`CIDL_ONEHOT_W-1:0] onehot_ch0;
  logic [`CIDL_ONEHOT_W-1:0] onehot_ch1;
  logic [15:0] conv_ch0;
  logic [15:0] conv_ch1;

  // Size is not decoded; every access is treated as a whole word
  logic unused_size;
  assign unused_size = ^hsize;

  // A request is taken only on NONSEQ or SEQ while the bus is ready
  assign take_req = hsel & htrans[1] & hready;

  // Read data waits one cycle so a write just before it is already stored
  always_comb begin
    next_state = state;
    next_addr_q = addr_q;
    next_hrdata = hrdata;
    case (state)
      CIDL_READ_WAIT: begin
        next_state = CIDL_READ_DONE;
        case (addr_q)
          `CIDL_OFS_ASSIST_CH0: next_hrdata = {16'h0000, conv_ch0};
          `CIDL_OFS_ASSIST_CH1: next_hrdata = {16'h0000, conv_ch1};
          `CIDL_OFS_RAW_CH0: next_hrdata = {21'h000000, held_ch0};
          `CIDL_OFS_RAW_CH1: next_hrdata = {21'h000000, held_ch1};
          default: next_hrdata = `CIDL_RDATA_ZERO;
        endcase
      end
      CIDL_IDLE, CIDL_WRITE, CIDL_READ_DONE: begin
        next_state = CIDL_IDLE;
        if (take_req) begin
          next_addr_q = haddr[`CIDL_ADDR_MSB:`CIDL_ADDR_LSB];
          if (hwrite) begin
            next_state = CIDL_WRITE;
          end else begin
            next_state = CIDL_READ_WAIT;
          end
        end
      end
      default: begin
        next_state = CIDL_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CIDL_IDLE;
      addr_q <= '0;
      hrdata <= `CIDL_RDATA_ZERO;
    end else begin
      state <= next_state;
      addr_q <= next_addr_q;
      hrdata <= next_hrdata;
    end
  end

  // Stall only in the first cycle of a read data phase
  assign hreadyout = (state != CIDL_READ_WAIT);
  assign hresp = `CIDL_HRESP_OKAY;

  // Write strobes; raw readback and unmapped offsets ignore writes
  assign wr_ch0 = (state == CIDL_WRITE) && (addr_q == `CIDL_OFS_ASSIST_CH0);
  assign wr_ch1 = (state == CIDL_WRITE) && (addr_q == `CIDL_OFS_ASSIST_CH1);

  // Channel 0 held identifier
  cidl_assist_reg u_reg_ch0 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_ch0),
    .wr_id(hwdata[`CIDL_ID_MSB:0]),
    .held_id(held_ch0)
  );

  // Channel 1 held identifier, fully independent of channel 0
  cidl_assist_reg u_reg_ch1 (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_ch1),
    .wr_id(hwdata[`CIDL_ID_MSB:0]),
    .held_id(held_ch1)
  );

  // Low identifier bits to one-hot mask
  cidl_onehot_dec u_dec_ch0 (
    .bin(held_ch0[`CIDL_LOWER_MSB:`CIDL_LOWER_LSB]),
    .onehot(onehot_ch0)
  );

  cidl_onehot_dec u_dec_ch1 (
    .bin(held_ch1[`CIDL_LOWER_MSB:`CIDL_LOWER_LSB]),
    .onehot(onehot_ch1)
  );

  // Mask in the high byte, row index in the low byte
  assign conv_ch0 = {onehot_ch0, held_ch0[`CIDL_UPPER_MSB:`CIDL_UPPER_LSB]};
  assign conv_ch1 = {onehot_ch1, held_ch1[`CIDL_UPPER_MSB:`CIDL_UPPER_LSB]};

endmodule : cidl_lookup_top
`default_nettype wire

//--- hdl/cidl_map.svh
// Register offsets, field positions and reset values of the ID lookup helper.
// Included by the package users; holds definitions only.
`ifndef CIDL_MAP_SVH
`define CIDL_MAP_SVH

// Byte offsets inside the slave window (word aligned)
`define CIDL_OFS_ASSIST_CH0 8'h00
`define CIDL_OFS_ASSIST_CH1 8'h04
`define CIDL_OFS_RAW_CH0 8'h08
`define CIDL_OFS_RAW_CH1 8'h0C

// Decoded address bits used by the slave
`define CIDL_ADDR_MSB 7
`define CIDL_ADDR_LSB 0

// Identifier field layout
`define CIDL_ID_W 11
`define CIDL_ID_MSB 10
`define CIDL_UPPER_MSB 10
`define CIDL_UPPER_LSB 3
`define CIDL_LOWER_MSB 2
`define CIDL_LOWER_LSB 0
`define CIDL_LOWER_W 3
`define CIDL_ONEHOT_W 8

// Reset value of the held identifier
`define CIDL_ID_RESET 11'h000

// Bus constants
`define CIDL_DATA_W 32
`define CIDL_RDATA_ZERO 32'h0000_0000
`define CIDL_HRESP_OKAY 1'b0

`endif

//--- hdl/cidl_pkg.sv
// Types shared by the ID lookup helper modules.
// Assumes cidl_map.svh for the numeric layout.
package cidl_pkg;

  // Bus slave phase tracking
  typedef enum logic [1:0] {
    CIDL_IDLE,
    CIDL_WRITE,
    CIDL_READ_WAIT,
    CIDL_READ_DONE
  } cidl_state_t;

endpackage : cidl_pkg

//--- hdl/cidl_onehot_dec.sv
// Three-to-eight one-hot decoder for the low identifier bits.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/10ps
`default_nettype none
`include "cidl_map.svh"

module cidl_onehot_dec
  import cidl_pkg::*;
(
  // Binary in
  input wire logic [`CIDL_LOWER_W-1:0] bin,
  // One-hot out
  output logic [`CIDL_ONEHOT_W-1:0] onehot
);

  // Value n sets bit n only
  always_comb begin
    onehot = '0;
    onehot[bin] = 1'b1;
  end

endmodule : cidl_onehot_dec
`default_nettype wire

//--- hdl/cidl_assist_reg.sv
// One channel's held standard identifier.
// Assumes a single-cycle write strobe from the bus slave in the same domain.
`timescale 1ns/10ps
`default_nettype none
`include "cidl_map.svh"

module cidl_assist_reg
  import cidl_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Write side
  input wire logic wr_en,
  input wire logic [`CIDL_ID_W-1:0] wr_id,
  // Held value
  output logic [`CIDL_ID_W-1:0] held_id
);

  logic [`CIDL_ID_W-1:0] next_held_id;

  // Keep the value until software writes a new one
  always_comb begin
    next_held_id = held_id;
    if (wr_en) begin
      next_held_id = wr_id;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_id <= `CIDL_ID_RESET;
    end else begin
      held_id <= next_held_id;
    end
  end

endmodule : cidl_assist_reg
`default_nettype wire

//--- testbench/cidl_lookup_sva.sv
// Assertions on the lookup helper bus ports.
// Assumes one slave, so hready is hreadyout looped back.
`timescale 1ns/10ps
`default_nettype none
module cidl_sva (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout
);
  logic rd, wr, ch, m;
  logic [10:0] standard_identifier_bits [2];
  wire take = hsel && htrans[1] && hreadyout;
  wire cv = rd && m && hreadyout;
  wire [10:0] cur = standard_identifier_bits[ch];
  // Shadow of held IDs; moves only as a data phase ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rd, wr, ch, m} <= 4'h0;
      standard_identifier_bits <= '{11'h000, 11'h000};
    end else if (hreadyout) begin
      if (wr && m) begin
        standard_identifier_bits[ch] <= hwdata[10:0];
      end
      {rd, wr, ch, m} <= {take && !hwrite, take && hwrite, haddr[2], haddr[7:3] == 5'h00};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence wait_s;
    !hreadyout ##1 hreadyout;
  endsequence
  rd_wait_a: assert property (take && !hwrite |=> wait_s)
    else $error("bad read wait");
  wr_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  no_wait_a: assert property (!rd |-> hreadyout)
    else $error("stray wait");
  row_index_a: assert property (cv |-> hrdata[7:0] == cur[10:3])
    else $error("bad row");
  one_hot_a: assert property (cv |-> hrdata[15:8] == 8'h01 << cur[2:0])
    else $error("bad mask");
  hi_zero_a: assert property (cv |-> hrdata[31:16] == 16'h0000)
    else $error("upper half set");
endmodule : cidl_sva

bind cidl_lookup_top cidl_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hrdata, .hreadyout);
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the lookup helper through its bus.
// Assumes a lone slave, so hready is hreadyout looped back.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hresp;
  int err_total = 0, check_count = 0;
  // 40 MHz
  always #12.5 hclk = ~hclk;
  cidl_lookup_top u_cidl_lookup_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp);
  // Count and flag differences
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One word transfer; no wait count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  // Reset value, channels apart, read-only and unmapped places
  task automatic t_chan();
    xfer(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000_0100);
    xfer(1'b1, 8'h04, 32'h7FF);
    xfer(1'b1, 8'h0C, 32'h123);
    xfer(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0100);
    xfer(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000_80FF);
    xfer(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0000_07FF);
    xfer(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("channel test done");
  endtask : t_chan
  // All low codes; junk above bit 10 must not land
  task automatic t_decode();
    logic [10:0] id;
    for (int n = 0; n < 8; n++) begin
      id = {8'hFF ^ (8'h01 << n), 3'(n)};
      xfer(1'b1, 8'h00, {21'h1FFFFF, id});
      xfer(1'b0, 8'h00, 32'h0);
      check(rd, {16'h0000, 8'h01 << n, id[10:3]});
    end
    $display("decode test done");
  endtask : t_decode
  // Software side: bitmap table, then accept or drop each received ID
  task automatic t_table();
    logic [7:0] table_q [256];
    logic [10:0] ids [8];
    logic [7:0] bits_q;
    ids = '{11'h000, 11'h00D, 11'h6F3, 11'h6F4, 11'h6FF, 11'h078, 11'h6F5, 11'h7FF};
    foreach (table_q[i]) begin
      table_q[i] = 8'h00;
    end
    // First five IDs are accepted, the rest must be dropped
    for (int k = 0; k < 5; k++) begin
      table_q[ids[k][10:3]][ids[k][2:0]] = 1'b1;
    end
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, 8'h04, {21'h0, ids[k]});
      xfer(1'b0, 8'h04, 32'h0);
      bits_q = table_q[rd[7:0]] & rd[15:8];
      check({31'h0, |bits_q}, {31'h0, k < 5});
    end
    $display("table test done");
  endtask : t_table
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Ten cycles of reset, then the tests
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_chan();
    t_decode();
    t_table();
    report_and_stop();
  end
  // Some 39 short transfers; far longer means a hang
  initial begin
    #50us;
    err_total++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
